// ---- rtl/rsw_pkg.sv ----
// constants for the reset supervisor and windowed watchdog
// assumes a single 10 MHz reference clock
package rsw_pkg;
  localparam int CLK_HZ = 10_000_000;
  // times in their own units
  localparam int RESET_DELAY_US = 16_500;
  localparam int WD_IGNORE_US = 16_000;
  localparam int WD_TRIGGER_US = 96_000;
  localparam int WD_FAULT_US = 8_000;
  localparam int UV_BLANK_NS = 6_000;
  localparam int UV_REACT_NS = 7_000;
  // derived cycle counts
  localparam int RESET_DELAY_CYC = RESET_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int WD_IGNORE_CYC = WD_IGNORE_US * (CLK_HZ / 1_000_000);
  localparam int WD_TRIGGER_CYC = WD_TRIGGER_US * (CLK_HZ / 1_000_000);
  localparam int WD_FAULT_CYC = WD_FAULT_US * (CLK_HZ / 1_000_000);
  localparam int UV_BLANK_CYC = (UV_BLANK_NS * (CLK_HZ / 1_000_000)
    + 999) / 1000;
  localparam int UV_REACT_CYC = (UV_REACT_NS * (CLK_HZ / 1_000_000))
    / 1000;
  localparam int CNT_W = 24;
  localparam int UV_W = 8;
  typedef enum logic [2:0] {
    ST_RESET,
    ST_IGNORE,
    ST_TRIGGER,
    ST_FAULT,
    ST_WD_OFF
  } rsw_state_e;
endpackage

// ---- rtl/rsw_top.sv ----
// reset supervisor with windowed watchdog on one active-low output
// assumes comparator flags and trigger pin are asynchronous to ref_clk
//
// Function
// - hold output low reset delay after power-on
// - all timing from internal cycle counters, cleared at each interval start
// - output release starts ignore interval
// - ignore expiry starts trigger interval
// - falling trigger edge restarts trigger interval
// - only falling edges count as triggers
// - missed trigger drives output low
// - reset and fault share one low output
// - undervoltage low after reaction, short pulses ignored
// - watchdog enabled by load-current flag
// - delay measured from upper threshold crossing
// - below lower threshold: low, then new delay
// - fault holds output low fault pulse length
module rsw_top #(
  parameter int RESET_DELAY = rsw_pkg::RESET_DELAY_CYC,
  parameter int IGNORE_LEN = rsw_pkg::WD_IGNORE_CYC,
  parameter int TRIGGER_LEN = rsw_pkg::WD_TRIGGER_CYC,
  parameter int FAULT_LEN = rsw_pkg::WD_FAULT_CYC,
  parameter int UV_BLANK = rsw_pkg::UV_BLANK_CYC,
  parameter int UV_REACT = rsw_pkg::UV_REACT_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // comparator flags
  input wire logic above_upper_threshold,
  input wire logic below_lower_threshold,
  input wire logic load_current_high,
  // supervised controller
  input wire logic watchdog_trigger_in,
  output logic reset_watchdog_out_n,
  // status
  output logic watchdog_active
);
  localparam int CW = rsw_pkg::CNT_W;
  localparam int UW = rsw_pkg::UV_W;
  // never react faster than blanking, whatever the parameters say
  localparam int UV_HOLD = (UV_REACT > UV_BLANK) ? UV_REACT : UV_BLANK;

  function automatic logic [CW-1:0] last_of(input int len);
    last_of = CW'(len - 1);
  endfunction

  // two-flop synchronisers for all async inputs
  logic [3:0] sync1_q, sync1_d, sync2_q, sync2_d;
  logic trig_prev_q, trig_prev_d;
  always_comb
  begin
    sync1_d = {load_current_high, below_lower_threshold,
               above_upper_threshold, watchdog_trigger_in};
    sync2_d = sync1_q;
    trig_prev_d = sync2_q[0];
  end
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      trig_prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      trig_prev_q <= trig_prev_d;
    end
  end
  logic trig_fall;
  assign trig_fall = trig_prev_q & ~sync2_q[0];

  // undervoltage filter: waits the longer of blanking and reaction before asserting
  logic [UW-1:0] uv_cnt_q, uv_cnt_d;
  logic uv_q, uv_d;
  always_comb
  begin
    uv_cnt_d = uv_cnt_q;
    uv_d = uv_q;
    if (!sync2_q[2])
    begin
      uv_cnt_d = '0;
      uv_d = 1'b0;
    end
    else if (uv_cnt_q < UW'(UV_HOLD - 1))
      uv_cnt_d = uv_cnt_q + UW'(1);
    else
      uv_d = 1'b1;
  end
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      uv_cnt_q <= '0;
      uv_q <= 1'b1;
    end
    else
    begin
      uv_cnt_q <= uv_cnt_d;
      uv_q <= uv_d;
    end
  end
  // reaction exceeds blanking, so any pulse under blanking never reaches it
  logic supply_ok;
  assign supply_ok = sync2_q[1] & ~uv_q;

  // supervisor sequencer; the state counter is the sole timebase
  rsw_pkg::rsw_state_e st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic out_q, out_d;
  logic act_q, act_d;

  function automatic logic load_en();
    load_en = sync2_q[3];
  endfunction

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q + CW'(1);
    case (st_q)
      rsw_pkg::ST_RESET:
      begin
        if (!supply_ok)
          cnt_d = '0;
        else if (cnt_q == last_of(RESET_DELAY))
        begin
          cnt_d = '0;
          st_d = load_en() ? rsw_pkg::ST_IGNORE : rsw_pkg::ST_WD_OFF;
        end
      end
      rsw_pkg::ST_IGNORE:
      begin
        if (!sync2_q[3])
          st_d = rsw_pkg::ST_WD_OFF;
        else if (cnt_q == last_of(IGNORE_LEN))
        begin
          cnt_d = '0;
          st_d = rsw_pkg::ST_TRIGGER;
        end
      end
      rsw_pkg::ST_TRIGGER:
      begin
        if (!sync2_q[3])
          st_d = rsw_pkg::ST_WD_OFF;
        else if (trig_fall)
          cnt_d = '0;
        else if (cnt_q == last_of(TRIGGER_LEN))
        begin
          cnt_d = '0;
          st_d = rsw_pkg::ST_FAULT;
        end
      end
      rsw_pkg::ST_FAULT:
      begin
        if (cnt_q == last_of(FAULT_LEN))
        begin
          cnt_d = '0;
          st_d = rsw_pkg::ST_IGNORE;
        end
      end
      rsw_pkg::ST_WD_OFF:
      begin
        cnt_d = '0;
        if (sync2_q[3])
          st_d = rsw_pkg::ST_IGNORE;
      end
      default:
      begin
        cnt_d = '0;
        st_d = rsw_pkg::ST_RESET;
      end
    endcase
    // undervoltage overrides every state
    if (!supply_ok && st_q != rsw_pkg::ST_RESET)
    begin
      cnt_d = '0;
      st_d = rsw_pkg::ST_RESET;
    end
    out_d = (st_d != rsw_pkg::ST_RESET) && (st_d != rsw_pkg::ST_FAULT);
    act_d = (st_d == rsw_pkg::ST_IGNORE) || (st_d == rsw_pkg::ST_TRIGGER);
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st_q <= rsw_pkg::ST_RESET;
      cnt_q <= '0;
      out_q <= 1'b0;
      act_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
      act_q <= act_d;
    end
  end
  assign reset_watchdog_out_n = out_q;
  assign watchdog_active = act_q;
endmodule

// ---- testbench/rsw_props.sv ----
// port assertions for the reset supervisor
// assumes it is bound into rsw_top below
module rsw_props #(
  parameter int IGNORE_LEN = 10,
  parameter int TRIGGER_LEN = 30
) (
  input logic ref_clk,
  input logic sys_rst,
  input logic above_upper_threshold,
  input logic below_lower_threshold,
  input logic load_current_high,
  input logic watchdog_trigger_in,
  input logic reset_watchdog_out_n,
  input logic watchdog_active
);
  int uv_q, uv_d, qt_q, qt_d;
  logic tr_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // only a fall or an inactive watchdog clears the quiet count, so rising edges cannot hide a miss
  always_comb
  begin
    uv_d = below_lower_threshold ? uv_q + 1 : 0;
    qt_d = watchdog_active && !(tr_q && !watchdog_trigger_in) ? qt_q + 1 : 0;
  end
  always_ff @(posedge ref_clk)
  begin
    uv_q <= uv_d;
    qt_q <= qt_d;
    tr_q <= watchdog_trigger_in;
  end
  sequence s_low7;
    !reset_watchdog_out_n [*7];
  endsequence
  property p_rst;
    disable iff (1'b0) sys_rst |=> !reset_watchdog_out_n;
  endproperty
  a_rst: assert property (p_rst) else $error("high in reset");
  property p_rel;
    $fell(sys_rst) |-> s_low7;
  endproperty
  a_rel: assert property (p_rel) else $error("early release");
  property p_fault;
    $fell(reset_watchdog_out_n) |-> s_low7;
  endproperty
  a_fault: assert property (p_fault) else $error("short low");
  property p_low;
    $rose(reset_watchdog_out_n) |-> !$past(reset_watchdog_out_n, 8);
  endproperty
  a_low: assert property (p_low) else $error("short low");
  property p_uv;
    uv_q == 80 |-> !reset_watchdog_out_n;
  endproperty
  a_uv: assert property (p_uv) else $error("no uv low");
  property p_quiet;
    qt_q <= IGNORE_LEN + TRIGGER_LEN + 8;
  endproperty
  a_quiet: assert property (p_quiet) else $error("missed fault");
  property p_act;
    watchdog_active |-> reset_watchdog_out_n;
  endproperty
  a_act: assert property (p_act) else $error("active while low");
  property p_off;
    !load_current_high [*8] |-> !watchdog_active;
  endproperty
  a_off: assert property (p_off) else $error("not off");
endmodule
bind rsw_top rsw_props #(.IGNORE_LEN(IGNORE_LEN), .TRIGGER_LEN(TRIGGER_LEN))
  u_rsw_props (.ref_clk, .sys_rst, .above_upper_threshold,
  .below_lower_threshold, .load_current_high, .watchdog_trigger_in,
  .reset_watchdog_out_n, .watchdog_active);

// ---- testbench/rsw_mcu.sv ----
// controller model toggling the trigger pin
// assumes run low means the controller hung
module rsw_mcu #(parameter int PERIOD = 24) (
  input logic ref_clk,
  input logic run,
  output logic trig
);
  int n = 0;
  initial trig = 1'b1;
  always @(negedge ref_clk)
  begin
    n = run ? (n + 1) % PERIOD : 0;
    trig <= !(run && n < PERIOD / 2);
  end
endmodule

// ---- testbench/tb.sv ----
// self-checking bench for the reset supervisor
// assumes the rtl package and top are compiled first
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, sys_rst = 1, above = 1, below = 0, load = 1, run = 1;
  logic trig, out_n, act;
  int error_cnt = 0, comparisons = 0, cycles = 0, lc;
  initial forever #50 ref_clk = !ref_clk;
  rsw_mcu #(.PERIOD(24)) u_rsw_mcu (.ref_clk, .run, .trig);
  rsw_top #(.RESET_DELAY(20), .IGNORE_LEN(10), .TRIGGER_LEN(30),
    .FAULT_LEN(8)) u_rsw_top (.ref_clk, .sys_rst,
    .above_upper_threshold(above), .below_lower_threshold(below),
    .load_current_high(load), .watchdog_trigger_in(trig),
    .reset_watchdog_out_n(out_n), .watchdog_active(act));
  task chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  // waits n cycles and counts those with the output low
  task cyc(input int n);
    lc = 0;
    repeat (n)
    begin
      @(negedge ref_clk);
      lc += (out_n !== 1'b1);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      end_sim;
    end
  end
  task t_power_on;
    cyc(15);
    chk(out_n === 1'b0 && act === 1'b0, "early release");
    cyc(20);
    chk(out_n === 1'b1 && act === 1'b1, "no release");
    $display("power-on done");
  endtask
  task t_kick;
    cyc(150);
    chk(lc == 0, "fault while kicked");
    $display("kick done");
  endtask
  task t_miss;
    run = 0;
    cyc(48);
    chk(lc >= 8 && lc <= 10 && act === 1'b1, "fault pulse");
    run = 1;
    $display("miss done");
  endtask
  task t_uv;
    below = 1;
    cyc(40);
    below = 0;
    cyc(100);
    chk(lc == 0, "short dip");
    below = 1;
    cyc(90);
    chk(out_n === 1'b0, "no uv low");
    below = 0;
    cyc(15);
    chk(out_n === 1'b0 && act === 1'b0, "early release");
    cyc(80);
    chk(out_n === 1'b1, "no release");
    $display("undervoltage done");
  endtask
  task t_supply_loss;
    above = 0;
    cyc(10);
    chk(out_n === 1'b0 && act === 1'b0, "no low on loss");
    above = 1;
    cyc(15);
    chk(out_n === 1'b0, "early release");
    cyc(20);
    chk(out_n === 1'b1 && act === 1'b1, "no release");
    $display("supply loss done");
  endtask
  task t_load_off;
    load = 0;
    run = 0;
    cyc(120);
    chk(lc == 0 && act === 1'b0, "watchdog on");
    $display("load off done");
  endtask
  initial
  begin
    cyc(2);
    sys_rst = 0;
    t_power_on;
    t_kick;
    t_miss;
    t_uv;
    t_supply_loss;
    t_load_off;
    end_sim;
  end
endmodule
